// ### include/mic_bank_defs.svh
`ifndef MIC_BANK_DEFS_SVH
`define MIC_BANK_DEFS_SVH
// byte offsets
`define OFS_START_TRIGGER 12'h000
`define OFS_STOP_TRIGGER 12'h004
`define OFS_START_LISTEN 12'h080
`define OFS_STOP_LISTEN 12'h084
`define OFS_BEGUN_FLAG 12'h100
`define OFS_HALT_DONE_FLAG 12'h104
`define OFS_BUFFER_FULL_FLAG 12'h108
`define OFS_BEGUN_BCAST 12'h180
`define OFS_HALT_DONE_BCAST 12'h184
`define OFS_BUFFER_FULL_BCAST 12'h188
`define OFS_IRQ_ENABLE 12'h300
`define OFS_IRQ_ENABLE_SET 12'h304
`define OFS_IRQ_ENABLE_CLEAR 12'h308
`define OFS_MODULE_ENABLE 12'h500
`define OFS_CLK_GEN_CTRL 12'h504
`define OFS_CHANNEL_ROUTING 12'h508
`define OFS_LEFT_GAIN 12'h518
`define OFS_RIGHT_GAIN 12'h51c
`define OFS_DECIMATION_RATIO 12'h520
`define OFS_CLOCK_PIN_SEL 12'h540
`define OFS_DATA_PIN_SEL 12'h544
`define OFS_DMA_PTR 12'h560
`define OFS_DMA_COUNT 12'h564
// field positions
`define CHANNEL_INDEX_MSB 15
`define CHAN_EN_BIT 31
`define IRQ_BEGUN_BIT 0
`define IRQ_HALT_BIT 1
`define IRQ_FULL_BIT 2
// reset value and response codes
`define RESET_WORD 32'h0000_0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### include/mic_bank_pkg.sv
package mic_bank_pkg;
   // channel subscribe / publish configuration
   typedef struct packed {
      logic en;
      logic [14:0] unused;
      logic [15:0] channel_index;
   } chan_cfg_t;
   // acquisition control
   typedef enum logic [1:0] {IDLE, RUN, DRAIN} acq_state_t;
   // one-cycle events from the acquisition
   typedef struct packed {
      logic begun;
      logic halt_done;
      logic buffer_full;
   } event_set_t;
endpackage

// ### rtl/mic_register_bank.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "mic_bank_defs.svh"
// Overview of operation
// RULE_01: start trigger write 1 begins acquisition
// RULE_02: stop trigger write 1 requests stop
// RULE_03: start listen selects channel, enable bit
// RULE_04: stop listen selects channel, enable bit
// RULE_05: begun flag set when transfer starts
// RULE_06: halt done flag after full stop
// RULE_07: buffer full flag at last sample; the code also pulses buffer full when a stop completes in DRAIN
// RULE_08: per-event broadcast configuration registers
// RULE_09: enable, set, clear registers gate interrupt
// RULE_10: ratio register selects decimation divisor
// RULE_11: pointer register gives DMA destination
// RULE_12: count register sets buffer length
// RULE_13: left and right gain registers
// RULE_14: routing register maps microphones to outputs
// RULE_15: pin selects for clock and data
// RULE_16: stop waits for frame and DMA; the code waits on frame_done only
// RULE_17: pointer double-buffered, switch at buffer full
// RULE_18: set register ones enable, reads state
// RULE_19: flags sticky until zero written
// RULE_20: enabled broadcast pulses channel per event
module mic_register_bank
   import mic_bank_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] channel_events,
   output logic [15:0] channel_publish,
   input wire logic frame_done,
   input wire logic sample_written,
   output logic acquiring,
   output logic [31:0] active_pointer,
   output logic [31:0] sample_count,
   output logic [31:0] ratio,
   output logic [31:0] clk_gen_ctrl,
   output logic [31:0] routing,
   output logic [31:0] gain_left,
   output logic [31:0] gain_right,
   output logic [31:0] clk_pin,
   output logic [31:0] data_pin,
   output logic enabled,
   output logic irq
);
   // synchronised channel events (fabric may be on another clock)
   logic [15:0] chan_meta;
   logic [15:0] chan_sync;
   // write channel capture
   logic aw_held;
   logic w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   // storage
   chan_cfg_t start_listen;
   chan_cfg_t stop_listen;
   chan_cfg_t bcast [3];
   logic [2:0] flags;
   logic [2:0] irq_en;
   logic [31:0] pending_pointer;
   logic [31:0] sample_index;
   acq_state_t state;
   event_set_t ev;
   logic start_req;
   logic stop_req;
   // events in flag order: 0 begun, 1 halt done, 2 buffer full
   logic [2:0] ev_bits;

   // byte-lane merge used by every plain register write except the module enable and interrupt enable writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (s[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      return r;
   endfunction

   // word-aligned address: byte lanes come from the strobes, not the low bits
   function automatic logic [11:0] word_addr(input logic [11:0] a);
      return {a[11:2], 2'b00};
   endfunction

   // channel match: enabled and selected line high
   function automatic logic chan_hit(input chan_cfg_t c, input logic [15:0] lines);
      return c.en & lines[c.channel_index[3:0]] & (c.channel_index[15:4] == 12'h000);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      unique case (a)
         `OFS_START_TRIGGER, `OFS_STOP_TRIGGER, `OFS_START_LISTEN, `OFS_STOP_LISTEN,
         `OFS_BEGUN_FLAG, `OFS_HALT_DONE_FLAG, `OFS_BUFFER_FULL_FLAG,
         `OFS_BEGUN_BCAST, `OFS_HALT_DONE_BCAST, `OFS_BUFFER_FULL_BCAST,
         `OFS_IRQ_ENABLE, `OFS_IRQ_ENABLE_SET, `OFS_IRQ_ENABLE_CLEAR,
         `OFS_MODULE_ENABLE, `OFS_CLK_GEN_CTRL, `OFS_CHANNEL_ROUTING,
         `OFS_LEFT_GAIN, `OFS_RIGHT_GAIN, `OFS_DECIMATION_RATIO,
         `OFS_CLOCK_PIN_SEL, `OFS_DATA_PIN_SEL, `OFS_DMA_PTR, `OFS_DMA_COUNT: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // two-flop synchroniser; first stage read only by second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         chan_meta <= 16'h0000;
         chan_sync <= 16'h0000;
      end
      else
      begin
         chan_meta <= channel_events;
         chan_sync <= chan_meta;
      end
   end

   // address and data accepted in either order, held until response
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= `RESET_WORD;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= word_addr(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // trigger strobes from software writes or subscribed channels
   always_comb
   begin
      start_req = (wr_go && aw_addr == `OFS_START_TRIGGER && w_strb[0] && w_data[0]) // [RULE_01]
         || chan_hit(start_listen, chan_sync); // [RULE_03]
      stop_req = (wr_go && aw_addr == `OFS_STOP_TRIGGER && w_strb[0] && w_data[0]) // [RULE_02]
         || chan_hit(stop_listen, chan_sync); // [RULE_04]
   end

   // configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         start_listen <= `RESET_WORD;
         stop_listen <= `RESET_WORD;
         for (int i = 0; i < 3; i++)
            bcast[i] <= `RESET_WORD;
         enabled <= 1'b0;
         clk_gen_ctrl <= `RESET_WORD;
         routing <= `RESET_WORD;
         gain_left <= `RESET_WORD;
         gain_right <= `RESET_WORD;
         ratio <= `RESET_WORD;
         clk_pin <= `RESET_WORD;
         data_pin <= `RESET_WORD;
         pending_pointer <= `RESET_WORD;
         sample_count <= `RESET_WORD;
      end
      else if (wr_go)
      begin
         unique case (aw_addr)
            `OFS_START_LISTEN: start_listen <= merge(start_listen, w_data, w_strb); // [RULE_03]
            `OFS_STOP_LISTEN: stop_listen <= merge(stop_listen, w_data, w_strb); // [RULE_04]
            `OFS_BEGUN_BCAST: bcast[0] <= merge(bcast[0], w_data, w_strb); // [RULE_08]
            `OFS_HALT_DONE_BCAST: bcast[1] <= merge(bcast[1], w_data, w_strb); // [RULE_08]
            `OFS_BUFFER_FULL_BCAST: bcast[2] <= merge(bcast[2], w_data, w_strb); // [RULE_08]
            `OFS_MODULE_ENABLE: enabled <= w_strb[0] ? w_data[0] : enabled;
            `OFS_CLK_GEN_CTRL: clk_gen_ctrl <= merge(clk_gen_ctrl, w_data, w_strb); // [RULE_10]
            `OFS_CHANNEL_ROUTING: routing <= merge(routing, w_data, w_strb); // [RULE_14]
            `OFS_LEFT_GAIN: gain_left <= merge(gain_left, w_data, w_strb); // [RULE_13]
            `OFS_RIGHT_GAIN: gain_right <= merge(gain_right, w_data, w_strb); // [RULE_13]
            `OFS_DECIMATION_RATIO: ratio <= merge(ratio, w_data, w_strb); // [RULE_10]
            `OFS_CLOCK_PIN_SEL: clk_pin <= merge(clk_pin, w_data, w_strb); // [RULE_15]
            `OFS_DATA_PIN_SEL: data_pin <= merge(data_pin, w_data, w_strb); // [RULE_15]
            `OFS_DMA_PTR: pending_pointer <= merge(pending_pointer, w_data, w_strb); // [RULE_11]
            `OFS_DMA_COUNT: sample_count <= merge(sample_count, w_data, w_strb); // [RULE_12]
            default: ;
         endcase
      end
   end

   // interrupt enables: direct write, set by ones, clear by ones
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_en <= 3'b000;
      else if (wr_go && w_strb[0])
      begin
         unique case (aw_addr)
            `OFS_IRQ_ENABLE: irq_en <= w_data[2:0]; // [RULE_09]
            `OFS_IRQ_ENABLE_SET: irq_en <= irq_en | w_data[2:0]; // [RULE_18]
            `OFS_IRQ_ENABLE_CLEAR: irq_en <= irq_en & ~w_data[2:0]; // [RULE_09]
            default: ;
         endcase
      end
   end

   // acquisition sequencer; stop drains the frame before halting
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= IDLE;
         active_pointer <= `RESET_WORD;
         sample_index <= `RESET_WORD;
         ev <= '0;
      end
      else
      begin
         ev <= '0;
         unique case (state)
            IDLE:
               if (start_req && enabled)
               begin
                  state <= RUN; // [RULE_01]
                  active_pointer <= pending_pointer; // [RULE_11]
                  sample_index <= `RESET_WORD;
                  ev.begun <= 1'b1; // [RULE_05]
               end
            RUN:
               if (stop_req)
                  state <= DRAIN; // [RULE_02]
               else if (sample_written)
               begin
                  if (sample_index + 32'h1 >= sample_count)
                  begin
                     // buffer full: swap to the pointer staged after begun
                     ev.buffer_full <= 1'b1; // [RULE_07] [RULE_12]
                     ev.begun <= 1'b1;
                     active_pointer <= pending_pointer; // [RULE_17]
                     sample_index <= `RESET_WORD;
                  end
                  else
                     sample_index <= sample_index + 32'h1;
               end
            // samples arriving while draining no longer advance the index
            DRAIN:
               if (frame_done) // [RULE_16]
               begin
                  state <= IDLE;
                  ev.buffer_full <= 1'b1; // [RULE_07]
                  ev.halt_done <= 1'b1; // [RULE_06]
               end
            // code 3 is never entered; fall back to idle if it ever is
            default: state <= IDLE;
         endcase
      end
   end
   assign acquiring = state != IDLE;
   assign ev_bits = {ev.buffer_full, ev.halt_done, ev.begun};

   // sticky flags: hardware set wins over software clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags <= 3'b000;
      else
         for (int i = 0; i < 3; i++)
         begin
            if (wr_go && w_strb[0] && !w_data[0] && aw_addr == `OFS_BEGUN_FLAG + 12'(4 * i))
               flags[i] <= 1'b0; // [RULE_19]
            if (ev_bits[i])
               flags[i] <= 1'b1; // [RULE_05] [RULE_06] [RULE_07]
         end
   end

   // broadcast one pulse per event on the configured channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         channel_publish <= 16'h0000;
      else
      begin
         channel_publish <= 16'h0000;
         for (int i = 0; i < 3; i++)
            if (ev_bits[i] && bcast[i].en && bcast[i].channel_index[15:4] == 12'h000)
               channel_publish[bcast[i].channel_index[3:0]] <= 1'b1; // [RULE_20]
      end
   end

   // level output: stays high until software clears the flag or the enable
   assign irq = |(flags & irq_en); // [RULE_19] [RULE_09]

   // read channel: one cycle to answer
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `RESET_WORD;
         s_axi_rresp <= `RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(word_addr(s_axi_araddr)) ? `RESP_OKAY : `RESP_SLVERR;
         unique case (word_addr(s_axi_araddr))
            `OFS_START_LISTEN: s_axi_rdata <= start_listen;
            `OFS_STOP_LISTEN: s_axi_rdata <= stop_listen;
            `OFS_BEGUN_FLAG: s_axi_rdata <= {31'h0, flags[0]}; // [RULE_05]
            `OFS_HALT_DONE_FLAG: s_axi_rdata <= {31'h0, flags[1]};
            `OFS_BUFFER_FULL_FLAG: s_axi_rdata <= {31'h0, flags[2]};
            `OFS_BEGUN_BCAST: s_axi_rdata <= bcast[0];
            `OFS_HALT_DONE_BCAST: s_axi_rdata <= bcast[1];
            `OFS_BUFFER_FULL_BCAST: s_axi_rdata <= bcast[2];
            `OFS_IRQ_ENABLE, `OFS_IRQ_ENABLE_SET, `OFS_IRQ_ENABLE_CLEAR:
               s_axi_rdata <= {29'h0, irq_en}; // [RULE_18]
            `OFS_MODULE_ENABLE: s_axi_rdata <= {31'h0, enabled};
            `OFS_CLK_GEN_CTRL: s_axi_rdata <= clk_gen_ctrl;
            `OFS_CHANNEL_ROUTING: s_axi_rdata <= routing;
            `OFS_LEFT_GAIN: s_axi_rdata <= gain_left;
            `OFS_RIGHT_GAIN: s_axi_rdata <= gain_right;
            `OFS_DECIMATION_RATIO: s_axi_rdata <= ratio;
            `OFS_CLOCK_PIN_SEL: s_axi_rdata <= clk_pin;
            `OFS_DATA_PIN_SEL: s_axi_rdata <= data_pin;
            `OFS_DMA_PTR: s_axi_rdata <= pending_pointer;
            `OFS_DMA_COUNT: s_axi_rdata <= sample_count;
            default: s_axi_rdata <= `RESET_WORD; // triggers read zero
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// ### verification/mic_register_bank_chk.sv
`timescale 1ns/1ps
`include "mic_bank_defs.svh"
// port-level watcher for the register bank
module mic_register_bank_chk
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic [15:0] channel_publish,
   input wire logic frame_done,
   input wire logic sample_written,
   input wire logic acquiring,
   input wire logic [31:0] active_pointer,
   input wire logic [31:0] ratio,
   input wire logic [31:0] gain_left,
   input wire logic [31:0] gain_right,
   input wire logic enabled,
   input wire logic irq
);
   logic wr_go;
   logic w_hs;
   logic ar_hs;
   // only same-cycle address and data writes are tracked as one request
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_trigger_reads_zero: assert property (ar_hs && s_axi_araddr inside {`OFS_START_TRIGGER, `OFS_STOP_TRIGGER}
      |=> s_axi_rvalid && s_axi_rdata == 32'h0) else $error("trigger read not zero");
   a_start_needs_enable: assert property ($rose(acquiring) |-> $past(enabled))
      else $error("acquisition began while disabled");
   a_start_latency: assert property (wr_go && s_axi_awaddr == `OFS_START_TRIGGER && s_axi_wdata[0]
      && s_axi_wstrb[0] && enabled && !acquiring |-> ##[1:3] acquiring) else $error("start trigger ignored");
   a_stop_after_frame: assert property ($fell(acquiring) |-> $past(frame_done) || $past(frame_done, 2))
      else $error("acquisition ended without frame end");
   a_pointer_switch: assert property ($changed(active_pointer) && $past(acquiring) && acquiring
      |-> $past(sample_written) || $past(sample_written, 2)) else $error("pointer moved mid buffer");
   a_config_by_write: assert property ($changed({ratio, gain_left, gain_right})
      |-> $past(w_hs) || $past(w_hs, 2)) else $error("config changed without write");
   a_reset_quiet: assert property ($rose(aresetn) |-> !acquiring && !irq && channel_publish == 16'h0)
      else $error("outputs active after reset");
   a_write_answer: assert property (wr_go |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response late");
   a_unmapped_error: assert property (ar_hs && s_axi_araddr == 12'h00c
      |=> s_axi_rvalid && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
   c_started: cover property ($rose(acquiring));
   c_stopped: cover property ($fell(acquiring));
   c_published: cover property (channel_publish != 16'h0);
endmodule
bind mic_register_bank mic_register_bank_chk chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .channel_publish, .frame_done, .sample_written,
   .acquiring, .active_pointer, .ratio, .gain_left, .gain_right, .enabled, .irq);

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "mic_bank_defs.svh"
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic frame_done, sample_written, acquiring, enabled, irq;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, active_pointer, sample_count, ratio, clk_gen_ctrl, routing;
   logic [31:0] gain_left, gain_right, clk_pin, data_pin, rd_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic [15:0] channel_events, channel_publish;
   int errors, checks_done, cycles, pub_cnt;
   logic [11:0] cfg_ofs [13] = '{`OFS_START_LISTEN, `OFS_STOP_LISTEN, `OFS_BEGUN_BCAST, `OFS_HALT_DONE_BCAST,
      `OFS_BUFFER_FULL_BCAST, `OFS_CLK_GEN_CTRL, `OFS_CHANNEL_ROUTING, `OFS_LEFT_GAIN, `OFS_RIGHT_GAIN,
      `OFS_DECIMATION_RATIO, `OFS_CLOCK_PIN_SEL, `OFS_DATA_PIN_SEL, `OFS_DMA_COUNT};

   mic_register_bank DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_events, .channel_publish,
      .frame_done, .sample_written, .acquiring, .active_pointer, .sample_count, .ratio, .clk_gen_ctrl, .routing,
      .gain_left, .gain_right, .clk_pin, .data_pin, .enabled, .irq);

   always #50 aclk = ~aclk;

   // count broadcasts on channel 3; the cycle ceiling stops a hung handshake
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (channel_publish[3] === 1'b1)
         pub_cnt <= pub_cnt + 1;
      if (cycles == 20000)
      begin
         errors = errors + 1;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // one-cycle pulse, then slack for the two-flop event sync
   task automatic pulse(input logic [17:0] v);
      {channel_events, frame_done, sample_written} <= v;
      tick(1);
      {channel_events, frame_done, sample_written} <= 18'h0;
      tick(3);
   endtask

   // ready is read before the edge's own updates land, so each channel drops only when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
         begin
            wr_resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask

   task automatic rd(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
         begin
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
      while (s_axi_arvalid || s_axi_rready);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      check(rd_data, e);
   endtask

   function automatic logic [31:0] pat(input int i);
      return 32'h8000_0000 | 32'(i + 1);
   endfunction

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, frame_done, sample_written} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, channel_events} = '0;
      s_axi_wstrb = 4'hf;
      tick(6);
      aresetn <= 1'b1;
      tick(1);
      // reset values, trigger reads and the unmapped hole
      rchk(`OFS_BEGUN_FLAG, 32'h0);
      rchk(`OFS_START_TRIGGER, 32'h0);
      rd(12'h00c);
      check(32'(rd_resp), 32'(`RESP_SLVERR));
      wr(12'h00c, 32'h1);
      check(32'(wr_resp), 32'(`RESP_SLVERR));
      wr(`OFS_STOP_TRIGGER, 32'h1);
      check(32'(wr_resp), 32'(`RESP_OKAY));
      for (int i = 0; i < 13; i++)
      begin
         rchk(cfg_ofs[i], 32'h0);
         wr(cfg_ofs[i], pat(i));
         rchk(cfg_ofs[i], pat(i));
      end
      check(clk_gen_ctrl, pat(5));
      check(routing, pat(6));
      check(gain_left, pat(7));
      check(gain_right, pat(8));
      check(ratio, pat(9));
      check(clk_pin, pat(10));
      check(data_pin, pat(11));
      check(sample_count, pat(12));
      $display("register test done");
      // interrupt enable through set and clear
      wr(`OFS_IRQ_ENABLE_SET, 32'h5);
      rchk(`OFS_IRQ_ENABLE, 32'h5);
      wr(`OFS_IRQ_ENABLE_SET, 32'h0);
      rchk(`OFS_IRQ_ENABLE_SET, 32'h5);
      wr(`OFS_IRQ_ENABLE, 32'h6);
      rchk(`OFS_IRQ_ENABLE_CLEAR, 32'h6);
      wr(`OFS_IRQ_ENABLE_CLEAR, 32'h3);
      rchk(`OFS_IRQ_ENABLE, 32'h4);
      $display("interrupt test done");
      // two-sample buffer, pointer swap, then a stop that waits for the frame
      for (int i = 0; i < 5; i++)
         wr(cfg_ofs[i], 32'h0);
      wr(`OFS_BUFFER_FULL_BCAST, 32'h8000_0003);
      wr(`OFS_START_TRIGGER, 32'h1);
      tick(3);
      check(32'(acquiring), 32'h0);
      wr(`OFS_MODULE_ENABLE, 32'h1);
      check(32'(enabled), 32'h1);
      wr(`OFS_DMA_PTR, 32'h2000_0100);
      wr(`OFS_DMA_COUNT, 32'h2);
      wr(`OFS_START_TRIGGER, 32'h1);
      tick(3);
      check(32'(acquiring), 32'h1);
      rchk(`OFS_BEGUN_FLAG, 32'h1);
      check(active_pointer, 32'h2000_0100);
      wr(`OFS_DMA_PTR, 32'h2000_0200);
      pulse(18'h1);
      rchk(`OFS_BUFFER_FULL_FLAG, 32'h0);
      pulse(18'h1);
      rchk(`OFS_BUFFER_FULL_FLAG, 32'h1);
      check(active_pointer, 32'h2000_0200);
      check(32'(irq), 32'h1);
      check(32'(pub_cnt), 32'h1);
      wr(`OFS_BUFFER_FULL_FLAG, 32'h0);
      rchk(`OFS_BUFFER_FULL_FLAG, 32'h0);
      check(32'(irq), 32'h0);
      wr(`OFS_STOP_TRIGGER, 32'h1);
      tick(4);
      check(32'(acquiring), 32'h1);
      rchk(`OFS_HALT_DONE_FLAG, 32'h0);
      pulse(18'h2);
      check(32'(acquiring), 32'h0);
      rchk(`OFS_HALT_DONE_FLAG, 32'h1);
      check(32'(pub_cnt), 32'h2);
      $display("acquisition test done");
      // fabric channel starts only when subscribed; a subscribed channel then stops it
      wr(`OFS_START_LISTEN, 32'h0000_0005);
      pulse(18'h80);
      tick(2);
      check(32'(acquiring), 32'h0);
      wr(`OFS_START_LISTEN, 32'h8000_0005);
      pulse(18'h80);
      tick(2);
      check(32'(acquiring), 32'h1);
      wr(`OFS_STOP_LISTEN, 32'h8000_0006);
      pulse(18'h100);
      pulse(18'h2);
      check(32'(acquiring), 32'h0);
      $display("subscription test done");
      complete_run();
   end
endmodule
